// [rtl/preset_strap_cfg.svh]
// Purpose: constants for the preset strap decoder
// Assumes: 200 MHz system clock, 16 MHz reference crystal
// Notes:   rates are given in kHz; cycle counts derive from them
`ifndef PRESET_STRAP_CFG_SVH
`define PRESET_STRAP_CFG_SVH

// rates in kHz
`define CLK_SYS_KHZ      18'h3_0D40
`define TICK_KHZ         18'h0_0C80
`define BUFFERED_CLOCK_OUTPUT_KHZ       18'h0_0320
`define XTAL_KHZ         17'h0_3E80

// half period of the clock output, in system cycles
`define BUFFERED_CLOCK_OUTPUT_HALF_CYC  ((`CLK_SYS_KHZ / `BUFFERED_CLOCK_OUTPUT_KHZ) / 18'h0_0002)
// crystal rate in the 10 kHz units of the carrier word
`define XTAL_UNITS       (`XTAL_KHZ / 17'h0_000A)

// auto-shutdown length in internal ticks
`define IDLE_TICKS       32'h0000_1000
// cycles to let the strap synchronisers settle before sampling;
// the filtered level needs four edges after reset, so latch on the fifth
`define SETTLE_CYC       3'h5

// preset values
`define DEV_PRESET_KHZ   6'h27
`define AMP_POWER_LEVEL_PRESET     3'h7
`define AMP_TUNING_CAPACITANCE_PRESET     5'h00

// reset values of the configuration outputs
`define AMP_POWER_LEVEL_RST        3'h0
`define AMP_TUNING_CAPACITANCE_RST        5'h00
`define DEV_RST_KHZ      6'h00

`endif

// [rtl/preset_strap_pkg.sv]
// Purpose: shared types of the preset strap decoder
// Assumes: nothing beyond the cfg header
// Notes:   enums carry no explicit codes
package preset_strap_pkg;

    // three-level strap state
    typedef enum logic [1:0] {LVL_GND, LVL_OPEN, LVL_VDD} tri_level_t;

    // operating state of the loader
    typedef enum logic [1:0] {ST_SAMPLE, ST_PROG, ST_ACTIVE, ST_SHUT} fsm_t;

endpackage

// [rtl/pin_sync.sv]
// Purpose: three-flop synchroniser with an agree filter
// Assumes: inputs are asynchronous pins
// Notes:   output follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    // pins in, filtered levels out
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t s_ff;
    sync_t nxt_s;

    // stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (s_ff.s2[i] == s_ff.s3[i]) begin
                nxt_s.q[i] = s_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= '0;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.q;
endmodule // pin_sync
`default_nettype wire

// [rtl/strap_decoder.sv]
// Purpose: maps the two strap levels to a mode and a carrier
// Assumes: 16 MHz reference for the synthesizer words
// Notes:   purely combinational; the caller latches the result
`timescale 1ns/10ps
`default_nettype none
`include "preset_strap_cfg.svh"
module strap_decoder
    import preset_strap_pkg::*;
(
    // strap levels and product variant
    input  wire tri_level_t  sel_high,
    input  wire tri_level_t  sel_low,
    input  wire logic        variant,
    // decoded configuration
    output logic             prog,
    output logic [16:0]      carrier,
    output logic [5:0]       synth_int,
    output logic [15:0]      synth_frac
);
    logic [31:0] car32;
    logic [31:0] rem32;

    // carrier table in 10 kHz units, variant 1 value first, then variant 0
    always_comb begin
        prog    = 1'b0;
        carrier = 17'h0_0000;
        case ({sel_high, sel_low})
            {LVL_GND, LVL_GND}: begin
                prog = 1'b1;
            end
            {LVL_GND, LVL_OPEN}: begin
                carrier = 17'h0_7B0C;
            end
            {LVL_GND, LVL_VDD}: begin
                carrier = variant ? 17'h0_A980 : 17'h1_65D0;
            end
            {LVL_OPEN, LVL_GND}: begin
                carrier = variant ? 17'h1_533A : 17'h1_62DA;
            end
            {LVL_OPEN, LVL_OPEN}: begin
                carrier = variant ? 17'h1_536F : 17'h1_6300;
            end
            {LVL_OPEN, LVL_VDD}: begin
                carrier = variant ? 17'h1_532E : 17'h1_62B0;
            end
            {LVL_VDD, LVL_GND}: begin
                carrier = variant ? 17'h1_53C9 : 17'h1_656C;
            end
            {LVL_VDD, LVL_OPEN}: begin
                carrier = variant ? 17'h1_5342 : 17'h0_A980;
            end
            {LVL_VDD, LVL_VDD}: begin
                carrier = variant ? 17'h1_5333 : 17'h0_A94E;
            end
            default: begin
                carrier = 17'h0_0000;
            end
        endcase
    end

    // integer and 16-bit fraction of carrier over the crystal rate
    always_comb begin
        car32      = {15'h0000, carrier};
        rem32      = car32 % {15'h0000, `XTAL_UNITS};
        synth_int  = 6'(car32 / {15'h0000, `XTAL_UNITS});
        synth_frac = 16'((rem32 << 16) / {15'h0000, `XTAL_UNITS});
    end
endmodule // strap_decoder
`default_nettype wire

// [rtl/preset_mode_strap_decoder.sv]
// Purpose: strap-driven preset loader with clock output and shutdown
// Assumes: straps arrive as two comparator levels per pin
// Notes:   the I2C register engine lives outside; this block passes it the
//          shared pin levels in every state, but lets it drive data only in programmable mode
`timescale 1ns/10ps
`default_nettype none
`include "preset_strap_cfg.svh"
module preset_mode_strap_decoder
    import preset_strap_pkg::*;
#(
    parameter int   IDLE_TICKS   = `IDLE_TICKS,
    parameter logic FREQ_VARIANT = 1'b0
) (
    // clock, reset, clock enable
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // strap comparators: above high threshold, below low threshold
    input  wire logic        strap_select_low_hi,
    input  wire logic        strap_select_low_lo,
    input  wire logic        strap_select_high_hi,
    input  wire logic        strap_select_high_lo,
    // data / serial-data pin
    input  wire logic        data_pin_i,
    output var  logic        data_pin_o,
    output var  logic        data_pin_oe,
    // clock-out / serial-clock pin
    input  wire logic        clk_pin_i,
    output var  logic        buffered_clock_output,
    output var  logic        clk_pin_oe,
    // I2C register engine side
    input  wire logic        i2c_sda_drive_low,
    output var  logic        i2c_scl,
    output var  logic        i2c_sda_in,
    // decoded configuration and status
    output var  logic        programmable_mode,
    output var  logic        powered_up,
    output var  logic        tx_data,
    output var  logic [16:0] carrier_10khz,
    output var  logic [5:0]  synth_int,
    output var  logic [15:0] synth_frac,
    output var  logic [5:0]  deviation_khz,
    output var  logic        gaussian_en,
    output var  logic [2:0]  amp_power_level,
    output var  logic [4:0]  amp_tuning_capacitance
);
    localparam int IW = $clog2(IDLE_TICKS + 1);

    typedef struct packed {
        fsm_t          st;
        logic [2:0]    settle;
        logic [17:0]   acc;
        logic [IW-1:0] idle;
        logic [7:0]    div;
        logic          clk_o;
        logic          clk_oe;
        logic          sda_oe;
        logic          prog;
        logic          up;
        logic          txd;
        logic          scl;
        logic          sda;
        logic [16:0]   carrier;
        logic [5:0]    sint;
        logic [15:0]   sfrac;
        logic [5:0]    dev;
        logic          gauss;
        logic [2:0]    pwr;
        logic [4:0]    cap;
    } state_t;

    localparam state_t RST_STATE = '{
        st: ST_SAMPLE, dev: `DEV_RST_KHZ, pwr: `AMP_POWER_LEVEL_RST,
        cap: `AMP_TUNING_CAPACITANCE_RST, default: '0};
    localparam logic [7:0] DIV_LAST = 8'(`BUFFERED_CLOCK_OUTPUT_HALF_CYC - 18'h0_0001);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_TICKS - 1);

    state_t      s_ff;
    state_t      nxt_s;
    logic [5:0]  pins_q;
    logic        data_s;
    logic        scl_s;
    tri_level_t  lvl_low;
    tri_level_t  lvl_high;
    logic        dec_prog;
    logic [16:0] dec_carrier;
    logic [5:0]  dec_int;
    logic [15:0] dec_frac;
    logic        tick;
    logic [18:0] acc_sum;

    // every pin input is asynchronous, so all pass the filter
    pin_sync #(
        .W (6)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d       ({clk_pin_i, data_pin_i,
                   strap_select_high_lo, strap_select_high_hi,
                   strap_select_low_lo, strap_select_low_hi}),
        .q       (pins_q)
    );

    assign data_s = pins_q[4];
    assign scl_s  = pins_q[5];

    // comparator pair to level; neither threshold crossed means open
    always_comb begin
        lvl_low  = LVL_OPEN;
        lvl_high = LVL_OPEN;
        if (pins_q[0]) begin
            lvl_low = LVL_VDD;
        end else if (pins_q[1]) begin
            lvl_low = LVL_GND;
        end
        if (pins_q[2]) begin
            lvl_high = LVL_VDD;
        end else if (pins_q[3]) begin
            lvl_high = LVL_GND;
        end
    end

    strap_decoder u_strap_decoder (
        .sel_high   (lvl_high),
        .sel_low    (lvl_low),
        .variant    (FREQ_VARIANT),
        .prog       (dec_prog),
        .carrier    (dec_carrier),
        .synth_int  (dec_int),
        .synth_frac (dec_frac)
    );

    // 3.2 MHz tick from a phase accumulator; 200/3.2 is not whole,
    // so ticks alternate 62 and 63 cycles but average exactly
    always_comb begin
        acc_sum = {1'b0, s_ff.acc} + {1'b0, `TICK_KHZ};
        tick    = (acc_sum >= {1'b0, `CLK_SYS_KHZ});
    end

    // next-state logic of the loader
    always_comb begin
        nxt_s        = s_ff;
        nxt_s.acc    = tick ? 18'(acc_sum - {1'b0, `CLK_SYS_KHZ})
                            : acc_sum[17:0];
        nxt_s.scl    = scl_s;
        nxt_s.sda    = data_s;
        nxt_s.sda_oe = 1'b0;
        nxt_s.clk_oe = 1'b0;
        nxt_s.clk_o  = 1'b0;
        nxt_s.txd    = 1'b0;
        case (s_ff.st)
            ST_SAMPLE: begin
                nxt_s.up = 1'b1;
                if (s_ff.settle != `SETTLE_CYC - 3'h1) begin
                    nxt_s.settle = s_ff.settle + 3'h1;
                end else begin
                    // latch once; held until the straps are sampled again after a wake
                    nxt_s.settle  = 3'h0;
                    nxt_s.idle    = '0;
                    nxt_s.div     = 8'h00;
                    nxt_s.prog    = dec_prog;
                    nxt_s.carrier = dec_carrier;
                    nxt_s.sint    = dec_int;
                    nxt_s.sfrac   = dec_frac;
                    if (dec_prog) begin
                        // registers come from the I2C engine instead
                        nxt_s.st    = ST_PROG;
                        nxt_s.dev   = `DEV_RST_KHZ;
                        nxt_s.gauss = 1'b0;
                        nxt_s.pwr   = `AMP_POWER_LEVEL_RST;
                        nxt_s.cap   = `AMP_TUNING_CAPACITANCE_RST;
                    end else begin
                        nxt_s.st    = ST_ACTIVE;
                        nxt_s.dev   = `DEV_PRESET_KHZ;
                        nxt_s.gauss = 1'b1;
                        nxt_s.pwr   = `AMP_POWER_LEVEL_PRESET;
                        nxt_s.cap   = `AMP_TUNING_CAPACITANCE_PRESET;
                    end
                end
            end
            ST_PROG: begin
                // clock pin stays an input; data pin is open drain
                nxt_s.clk_oe = 1'b0;
                nxt_s.sda_oe = i2c_sda_drive_low;
            end
            ST_ACTIVE: begin
                nxt_s.clk_oe = 1'b1;
                nxt_s.txd    = data_s;
                if (s_ff.div == DIV_LAST) begin
                    nxt_s.div   = 8'h00;
                    nxt_s.clk_o = ~s_ff.clk_o;
                end else begin
                    nxt_s.div   = s_ff.div + 8'h01;
                    nxt_s.clk_o = s_ff.clk_o;
                end
                if (data_s) begin
                    nxt_s.idle = '0;
                end else if (tick && s_ff.idle == IDLE_LAST) begin
                    nxt_s.idle = '0;
                    nxt_s.st   = ST_SHUT;
                end else if (tick) begin
                    nxt_s.idle = s_ff.idle + IW'(1);
                end
            end
            ST_SHUT: begin
                nxt_s.up = 1'b0;
                if (data_s) begin
                    nxt_s.settle = 3'h0;
                    nxt_s.st     = ST_SAMPLE;
                end
            end
            default: begin
                nxt_s = RST_STATE;
            end
        endcase
    end

    // single state register, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_ff <= RST_STATE;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register, except data_pin_o, which is tied low
    assign data_pin_o             = 1'b0;
    assign data_pin_oe            = s_ff.sda_oe;
    assign buffered_clock_output  = s_ff.clk_o;
    assign clk_pin_oe             = s_ff.clk_oe;
    assign i2c_scl                = s_ff.scl;
    assign i2c_sda_in             = s_ff.sda;
    assign programmable_mode      = s_ff.prog;
    assign powered_up             = s_ff.up;
    assign tx_data                = s_ff.txd;
    assign carrier_10khz          = s_ff.carrier;
    assign synth_int              = s_ff.sint;
    assign synth_frac             = s_ff.sfrac;
    assign deviation_khz          = s_ff.dev;
    assign gaussian_en            = s_ff.gauss;
    assign amp_power_level        = s_ff.pwr;
    assign amp_tuning_capacitance = s_ff.cap;

    // checks on the loader
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence shut_wake_s;
        s_ff.st == ST_SHUT && data_s && clk_en;
    endsequence

    sequence sample_last_s;
        s_ff.st == ST_SAMPLE && s_ff.settle == `SETTLE_CYC - 3'h1
            && clk_en;
    endsequence

    prog_select_a: assert property (
        sample_last_s ##0 (lvl_low == LVL_GND && lvl_high == LVL_GND)
            |=> s_ff.st == ST_PROG && programmable_mode)
        else $error("grounded straps did not select programmable mode");

    prog_clkpin_a: assert property (
        s_ff.st == ST_PROG |-> !clk_pin_oe && i2c_scl == $past(scl_s))
        else $error("clock pin driven in programmable mode");

    prog_sdapin_a: assert property (
        s_ff.st == ST_PROG && $past(s_ff.st) == ST_PROG && $past(clk_en)
            |-> data_pin_oe == $past(i2c_sda_drive_low) && !data_pin_o)
        else $error("data pin does not follow the serial engine");

    buffered_clock_output_period_a: assert property (
        clk_en && s_ff.st == ST_ACTIVE && nxt_s.st == ST_ACTIVE
            && s_ff.div == DIV_LAST
            |=> clk_pin_oe && buffered_clock_output != $past(s_ff.clk_o))
        else $error("clock output half period wrong");

    preset_shape_a: assert property (
        s_ff.st == ST_ACTIVE
            |-> deviation_khz == 6'h27 && gaussian_en && !programmable_mode)
        else $error("preset deviation or shaping wrong");

    preset_power_a: assert property (
        s_ff.st == ST_ACTIVE |-> amp_power_level == 3'h7)
        else $error("preset power code not maximum");

    preset_cap_a: assert property (
        s_ff.st == ST_ACTIVE |-> amp_tuning_capacitance == 5'h00)
        else $error("preset tuning capacitance not zero");

    idle_clear_a: assert property (
        s_ff.st == ST_ACTIVE && data_s && clk_en |=> s_ff.idle == '0)
        else $error("high data did not clear idle counter");

    auto_shut_a: assert property (
        s_ff.st == ST_ACTIVE && !data_s && tick && clk_en
            && s_ff.idle == IDLE_LAST
            |=> s_ff.st == ST_SHUT ##1 !powered_up || data_s)
        else $error("idle count end did not shut down");

    data_wake_a: assert property (
        shut_wake_s |=> s_ff.st == ST_SAMPLE ##1 powered_up)
        else $error("data pulse did not wake the device");

    cfg_hold_a: assert property (
        s_ff.st != ST_SAMPLE && $past(s_ff.st) != ST_SAMPLE
            |-> $stable(carrier_10khz) && $stable(programmable_mode))
        else $error("configuration changed outside sampling");
endmodule // preset_mode_strap_decoder
`default_nettype wire

// [test/strap_host_model.sv]
// Purpose: far-side controller that drives the shared data and clock pins
// Assumes: the block samples the pins on rising clk_sys edges
// Notes:   levels change on falling edges only, so no sampling race
`timescale 1ns/10ps
`default_nettype none
module strap_host_model (
    // clock
    input  wire logic clk_sys,
    // pin levels driven by the controller
    output var  logic data_drive,
    output var  logic scl_drive
);
    // idle data low: an awake device starts counting toward shutdown
    initial begin
        data_drive = 1'b0;
        scl_drive  = 1'b1;
    end

    // preset use: the data pin is the only thing the controller touches
    task automatic send_bit(input logic lvl, input int n);
        @(negedge clk_sys);
        data_drive = lvl;
        repeat (n - 1) @(negedge clk_sys);
    endtask

    // programmable use: both shared pins act as the serial bus
    task automatic bus_levels(input logic scl, input logic sda);
        @(negedge clk_sys);
        scl_drive  = scl;
        data_drive = sda;
    endtask
endmodule // strap_host_model
`default_nettype wire

// [test/preset_mode_strap_decoder_tb.sv]
// Purpose: self-checking bench for the strap-driven preset loader
// Assumes: both carrier variants built side by side, short idle count
// Notes:   straps coded 0 ground, 1 open, 2 supply
`timescale 1ns/10ps
`default_nettype none
module preset_mode_strap_decoder_tb;
    localparam int IDLE = 8;
    // carrier per strap pair (high*3+low), 10 kHz units, per variant
    localparam logic [16:0] CARR [2][9] = '{
        '{17'h0_0000, 17'h0_7B0C, 17'h1_65D0, 17'h1_62DA, 17'h1_6300,
          17'h1_62B0, 17'h1_656C, 17'h0_A980, 17'h0_A94E},
        '{17'h0_0000, 17'h0_7B0C, 17'h0_A980, 17'h1_533A, 17'h1_536F,
          17'h1_532E, 17'h1_53C9, 17'h1_5342, 17'h1_5333}};
    logic             clk_sys;
    logic             rst_b;
    logic             clk_en;
    logic [1:0]       sel_hi;
    logic [1:0]       sel_lo;
    logic             sda_drive_low;
    logic             data_drive;
    logic             scl_drive;
    logic [1:0]       data_in;
    logic [1:0]       clk_in;
    logic [1:0]       data_oe;
    logic [1:0]       data_o;
    logic             frz;
    logic [1:0]       clk_out;
    logic [1:0]       clk_oe;
    logic [1:0]       scl_seen;
    logic [1:0]       sda_seen;
    logic [1:0]       prog;
    logic [1:0]       pwr_up;
    logic [1:0]       tx;
    logic [1:0]       gauss;
    logic [1:0][16:0] carr;
    logic [1:0][5:0]  s_int;
    logic [1:0][15:0] s_frac;
    logic [1:0][5:0]  dev;
    logic [1:0][2:0]  amp_pwr;
    logic [1:0][4:0]  amp_cap;
    int               fails;
    int               n_checks;
    int               len;

    // one instance per carrier variant; pins resolved from all drivers
    for (genvar v = 0; v < 2; v++) begin : g_var
        // open drain with pull-up: any low driver wins
        assign data_in[v] = data_drive & (data_oe[v] ? data_o[v] : 1'b1);
        assign clk_in[v]  = clk_oe[v] ? clk_out[v] : scl_drive;
        preset_mode_strap_decoder #(
            .IDLE_TICKS   (IDLE),
            .FREQ_VARIANT (1'(v))
        ) i_preset_mode_strap_decoder (
            .clk_sys (clk_sys), .rst_b (rst_b), .clk_en (clk_en),
            .strap_select_low_hi   (sel_lo == 2'h2),
            .strap_select_low_lo   (sel_lo == 2'h0),
            .strap_select_high_hi  (sel_hi == 2'h2),
            .strap_select_high_lo  (sel_hi == 2'h0),
            .data_pin_i (data_in[v]), .data_pin_o (data_o[v]),
            .data_pin_oe (data_oe[v]),
            .clk_pin_i (clk_in[v]), .buffered_clock_output (clk_out[v]),
            .clk_pin_oe (clk_oe[v]), .i2c_sda_drive_low (sda_drive_low),
            .i2c_scl (scl_seen[v]), .i2c_sda_in (sda_seen[v]),
            .programmable_mode (prog[v]), .powered_up (pwr_up[v]),
            .tx_data (tx[v]), .carrier_10khz (carr[v]), .synth_int (s_int[v]),
            .synth_frac (s_frac[v]), .deviation_khz (dev[v]),
            .gaussian_en (gauss[v]), .amp_power_level (amp_pwr[v]),
            .amp_tuning_capacitance (amp_cap[v])
        );
    end

    // far-side controller
    strap_host_model i_strap_host_model (
        .clk_sys    (clk_sys),
        .data_drive (data_drive),
        .scl_drive  (scl_drive)
    );

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // straps are set before release so the sample window sees them settled
    task automatic restart(input logic [1:0] h, input logic [1:0] l);
        @(negedge clk_sys);
        rst_b  = 1'b0;
        sel_hi = h;
        sel_lo = l;
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask

    // whole decoded configuration of one instance against the tables
    task automatic chk_cfg(input int v, input int idx);
        logic [31:0] c;
        logic [31:0] f;
        c = 32'(CARR[v][idx]);
        f = ((c % 32'h0000_0640) << 16) / 32'h0000_0640;
        chk("programmable_mode", 32'(idx == 0), 32'(prog[v]));
        chk("carrier_10khz", c, 32'(carr[v]));
        chk("synth_int", c / 32'h0000_0640, 32'(s_int[v]));
        chk("synth_frac", f, 32'(s_frac[v]));
        chk("deviation_khz", (idx == 0) ? 0 : 32'h0000_0027, 32'(dev[v]));
        chk("gaussian_en", 32'(idx != 0), 32'(gauss[v]));
        chk("amp_power_level", (idx == 0) ? 0 : 7, 32'(amp_pwr[v]));
        chk("amp_tuning_capacitance", 0, 32'(amp_cap[v]));
    endtask

    // bounded wait on the power flag of the first instance
    task automatic wait_power(input logic lvl, input int n);
        int k;
        k = 0;
        while (pwr_up[0] !== lvl && k < n) begin
            @(negedge clk_sys);
            k++;
        end
        chk("powered_up", 32'(lvl), 32'(pwr_up[0]));
    endtask

    // cycles until the clock output leaves its present level
    task automatic run_len(output int n);
        logic lvl;
        lvl = clk_out[0];
        n = 0;
        while (clk_out[0] === lvl && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // main sequence
    initial begin
        clk_en = 1'b1;
        rst_b = 1'b0;
        sel_hi = 2'h0;
        sel_lo = 2'h0;
        sda_drive_low = 1'b0;
        fails = 0;
        n_checks = 0;
        for (int h = 0; h < 3; h++) begin
            for (int l = 0; l < 3; l++) begin
                restart(2'(h), 2'(l));
                for (int v = 0; v < 2; v++) begin
                    chk_cfg(v, h * 3 + l);
                end
            end
        end
        // programmable mode: shared pins become the serial bus
        restart(2'h0, 2'h0);
        i_strap_host_model.bus_levels(1'b0, 1'b0);
        repeat (6) @(negedge clk_sys);
        chk("i2c_scl", 0, 32'(scl_seen[0]));
        chk("i2c_sda_in", 0, 32'(sda_seen[0]));
        chk("clk_pin_oe", 0, 32'(clk_oe[0]));
        i_strap_host_model.bus_levels(1'b1, 1'b1);
        sda_drive_low = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("i2c_scl", 1, 32'(scl_seen[0]));
        chk("data_pin_oe", 1, 32'(data_oe[0]));
        chk("data_pin_o", 0, 32'(data_o[0]));
        chk("i2c_sda_in", 0, 32'(sda_seen[0]));
        sda_drive_low = 1'b0;
        i_strap_host_model.bus_levels(1'b1, 1'b0);
        repeat (600) @(negedge clk_sys);
        chk("powered_up", 1, 32'(pwr_up[0]));
        // preset with data held high: clock output runs, data passes
        i_strap_host_model.send_bit(1'b1, 1);
        restart(2'h1, 2'h1);
        chk("tx_data", 1, 32'(tx[0]));
        chk("clk_pin_oe", 1, 32'(clk_oe[0]));
        run_len(len);
        run_len(len);
        chk("clock half period", 125, 32'(len));
        run_len(len);
        chk("clock half period", 125, 32'(len));
        // strap moves while awake are not taken
        sel_hi = 2'h2;
        sel_lo = 2'h2;
        repeat (10) @(negedge clk_sys);
        chk("carrier_10khz", 32'(CARR[0][4]), 32'(carr[0]));
        // clock enable low: a running output would toggle once in 125
        clk_en = 1'b0;
        frz = clk_out[0];
        repeat (125) @(negedge clk_sys);
        chk("clock output frozen", 32'(frz), 32'(clk_out[0]));
        clk_en = 1'b1;
        // idle count, restart on a high level, then shutdown
        i_strap_host_model.send_bit(1'b0, 400);
        chk("powered_up", 1, 32'(pwr_up[0]));
        chk("tx_data", 0, 32'(tx[0]));
        i_strap_host_model.send_bit(1'b1, 4);
        i_strap_host_model.send_bit(1'b0, 400);
        chk("powered_up", 1, 32'(pwr_up[0]));
        wait_power(1'b0, 200);
        chk("clk_pin_oe", 0, 32'(clk_oe[0]));
        // wake on data: straps sampled afresh
        i_strap_host_model.send_bit(1'b1, 20);
        chk("powered_up", 1, 32'(pwr_up[0]));
        chk("carrier_10khz", 32'(CARR[0][8]), 32'(carr[0]));
        chk("carrier_10khz", 32'(CARR[1][8]), 32'(carr[1]));
        conclude();
    end

    // hang guard: the sequence needs about 2300 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        conclude();
    end
endmodule // preset_mode_strap_decoder_tb
`default_nettype wire
